//--- rtl/todc_pkg.sv
// package: constants and types of the time of day calendar clock
package todc_pkg;
   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int CLK_HZ      = 40_000_000;
   localparam int TICK_MS     = 100;
   localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
   localparam int SCAN_US     = 1000;
   localparam int SCAN_CYC    = CLK_HZ / 1_000_000 * SCAN_US;
   localparam logic [2:0] LINE50_PER_TICK = 3'h5;
   localparam logic [2:0] LINE60_PER_TICK = 3'h6;
   localparam logic [19:0] DAY_TICKS      = 20'hd2f00;
   // ---------------------------------------------
   // register byte offsets
   // ---------------------------------------------
   localparam logic [7:0] A_CMD = 8'h00, A_SEC = 8'h04, A_MIN = 8'h08, A_HR = 8'h0c;
   localparam logic [7:0] A_DOW = 8'h10, A_DATE = 8'h14, A_MON = 8'h18, A_YR = 8'h1c;
   localparam logic [7:0] A_HR12 = 8'h20, A_BIN = 8'h24, A_ASEC = 8'h28, A_AMIN = 8'h2c;
   localparam logic [7:0] A_AHR = 8'h30, A_ADATE = 8'h34, A_AMON = 8'h38, A_ACTL = 8'h3c;
   localparam logic [7:0] A_RLD = 8'h40, A_RCNT = 8'h44, A_ISTAT = 8'h48, A_IMASK = 8'h4c;
   localparam logic [7:0] A_USER = 8'h50, A_TENTH = 8'h54;
   // ---------------------------------------------
   // fields, codes, reset values
   // ---------------------------------------------
   localparam int I_ABS = 0, I_REL = 1, I_PF = 2;
   localparam int C_AEN = 0, C_ADATE = 1, C_REN = 2;
   localparam logic [7:0] ST_READY = 8'hee, ST_ACK = 8'hff;
   localparam logic [7:0] CM_OFF = 8'he0, CM_D12 = 8'he1, CM_D24 = 8'he2, CM_DDATE = 8'he3;
   localparam logic [7:0] CM_DUSER = 8'he4, CM_XTAL = 8'he5, CM_L50 = 8'he6, CM_L60 = 8'he7;
   localparam logic [7:0] CM_IDIS = 8'he8;
   localparam logic [7:0] R_ONE = 8'h01, R_ZERO = 8'h00, MAX_SEC = 8'h59, MAX_HR = 8'h23;
   localparam logic [7:0] MAX_MON = 8'h12;
   localparam logic [3:0] MAX_TENTH = 4'h9, BLANK = 4'hf;
   localparam logic [2:0] MAX_DOW = 3'h7, LAST_DIGIT = 3'h5;

   typedef enum logic [1:0] {TB_XTAL, TB_L50, TB_L60} todc_tb_t;
   typedef enum logic [2:0] {DM_OFF, DM_12, DM_24, DM_DATE, DM_USER} todc_dm_t;
   typedef enum logic {CS_READY, CS_ACK} todc_cs_t;

   typedef struct packed {
      logic [7:0] sec, min, hr, date, mon, yr;
      logic [2:0] dow;
      logic [3:0] tenth;
   } todc_time_t;

   // ---------------------------------------------
   // block state, one register set
   // ---------------------------------------------
   typedef struct packed {
      logic                 ln1, ln2, ln3, pf1, pf2;
      todc_tb_t             tb;
      logic [21:0]          div;
      logic [2:0]           lcnt;
      todc_time_t           t;
      todc_time_t           al;
      logic [2:0]           actl;
      logic [19:0]          rld, rcnt;
      logic [2:0]           ist, imsk;
      logic [23:0]          user;
      todc_dm_t             dm;
      todc_cs_t             cs;
      logic [15:0]          scan;
      logic [2:0]           dig;
      logic [31:0]          prdata;
      logic                 pready, pslverr, irq;
      logic [3:0]           bcd;
      logic                 tind, dind, am, pm;
   } todc_state_t;

   // ---------------------------------------------
   // bcd helpers
   // ---------------------------------------------
   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
      if (v >= hi) return {1'b1, lo};
      if (v[3:0] == 4'h9) return {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
      return {1'b0, 8'(v + 8'h01)};
   endfunction : bcd_inc

   function automatic logic [6:0] bcd2bin(input logic [7:0] v);
      logic [7:0] t;
      t = {4'h0, v[7:4]};
      return 7'((t << 3) + (t << 1) + {4'h0, v[3:0]});
   endfunction : bcd2bin

   // year 00 is a leap year, which holds for the whole 2000-2099 span
   function automatic logic [7:0] mon_days(input logic [7:0] m, input logic [7:0] y);
      logic [6:0] yb;
      yb = bcd2bin(y);
      unique case (m)
         8'h02:                      return (yb[1:0] == 2'h0) ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
         default:                    return 8'h31;
      endcase
   endfunction : mon_days
endpackage : todc_pkg

//--- rtl/todc_top.sv
// module: time of day calendar clock with apb registers and display scan
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module todc_top #(
   parameter int TICK_CYCLES = todc_pkg::TICK_CYC,
   parameter int SCAN_CYCLES = todc_pkg::SCAN_CYC
) (
   // clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESETN_I,
   // apb slave
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   // pins
   input  wire logic        LINE_TB_I,
   input  wire logic        POWER_FAIL_I,
   output logic             IRQ_OUT_O,
   // display
   output logic      [2:0]  DIGIT_SELECT_O,
   output logic      [3:0]  BCD_O,
   output logic             TIME_IND_O,
   output logic             DATE_IND_O,
   output logic             AM_O,
   output logic             PM_O
);
   // ---------------------------------------------
   // state
   // ---------------------------------------------
   todc_pkg::todc_state_t s_q, s_d;
   logic        tick_w, abs_w, rel_w, wr_w, rd_w, hit_w;
   logic [7:0]  h12_w, wd_w;
   logic [16:0] bin_w;
   logic [8:0]  c_s, c_m, c_h, c_d, c_mo, c_y;
   logic [23:0] disp_w;
   todc_pkg::todc_time_t nt_w;

   always_comb begin
      s_d    = s_q;
      tick_w = 1'b0;
      abs_w  = 1'b0;
      rel_w  = 1'b0;
      hit_w  = 1'b0;
      wd_w   = PWDATA_I[7:0];
      wr_w   = PSEL_I && PENABLE_I && s_q.pready && PWRITE_I;
      rd_w   = PSEL_I && PENABLE_I && s_q.pready && !PWRITE_I;
      // ---------------------------------------------
      // synchronisers
      // ---------------------------------------------
      s_d.ln1 = LINE_TB_I;
      s_d.ln2 = s_q.ln1;
      s_d.ln3 = s_q.ln2;
      s_d.pf1 = POWER_FAIL_I;
      s_d.pf2 = s_q.pf1;
      // ---------------------------------------------
      // tenth tick
      // ---------------------------------------------
      if (s_q.tb == todc_pkg::TB_XTAL) begin
         s_d.lcnt = 3'h0;
         if (s_q.div >= 22'(TICK_CYCLES - 1)) begin
            s_d.div = 22'h0;
            tick_w  = 1'b1;
         end else begin
            s_d.div = s_q.div + 22'h1;
         end
      end else begin
         s_d.div = 22'h0;
         if (s_q.ln2 && !s_q.ln3) begin
            if (s_q.lcnt >= ((s_q.tb == todc_pkg::TB_L50) ? todc_pkg::LINE50_PER_TICK
                                                           : todc_pkg::LINE60_PER_TICK) - 3'h1) begin
               s_d.lcnt = 3'h0;
               tick_w   = 1'b1;
            end else begin
               s_d.lcnt = s_q.lcnt + 3'h1;
            end
         end
      end
      // ---------------------------------------------
      // calendar: each carry ripples upward
      // ---------------------------------------------
      nt_w = s_q.t;
      c_s  = todc_pkg::bcd_inc(s_q.t.sec, todc_pkg::R_ZERO, todc_pkg::MAX_SEC);
      c_m  = todc_pkg::bcd_inc(s_q.t.min, todc_pkg::R_ZERO, todc_pkg::MAX_SEC);
      c_h  = todc_pkg::bcd_inc(s_q.t.hr, todc_pkg::R_ZERO, todc_pkg::MAX_HR);
      c_d  = todc_pkg::bcd_inc(s_q.t.date, todc_pkg::R_ONE, todc_pkg::mon_days(s_q.t.mon, s_q.t.yr));
      c_mo = todc_pkg::bcd_inc(s_q.t.mon, todc_pkg::R_ONE, todc_pkg::MAX_MON);
      c_y  = todc_pkg::bcd_inc(s_q.t.yr, todc_pkg::R_ZERO, 8'h99);
      if (tick_w) begin
         if (s_q.t.tenth >= todc_pkg::MAX_TENTH) begin
            nt_w.tenth = 4'h0;
            nt_w.sec   = c_s[7:0];
            if (c_s[8]) begin
               nt_w.min = c_m[7:0];
               if (c_m[8]) begin
                  nt_w.hr = c_h[7:0];
                  if (c_h[8]) begin
                     nt_w.dow  = (s_q.t.dow >= todc_pkg::MAX_DOW) ? 3'h1 : s_q.t.dow + 3'h1;
                     nt_w.date = c_d[7:0];
                     if (c_d[8]) begin
                        nt_w.mon = c_mo[7:0];
                        if (c_mo[8]) begin
                           nt_w.yr = c_y[7:0];
                        end
                     end
                  end
               end
            end
            // compare on the second edge so a match fires once
            hit_w = (nt_w.sec == s_q.al.sec) && (nt_w.min == s_q.al.min) && (nt_w.hr == s_q.al.hr)
                    && (!s_q.actl[todc_pkg::C_ADATE]
                        || ((nt_w.date == s_q.al.date) && (nt_w.mon == s_q.al.mon)));
            abs_w = hit_w && s_q.actl[todc_pkg::C_AEN];
         end else begin
            nt_w.tenth = s_q.t.tenth + 4'h1;
         end
      end
      s_d.t = nt_w;
      // ---------------------------------------------
      // relative down counter
      // ---------------------------------------------
      if (tick_w && s_q.actl[todc_pkg::C_REN]) begin
         if (s_q.rcnt <= 20'h1) begin
            rel_w  = 1'b1;
            s_d.rcnt = s_q.rld;
         end else begin
            s_d.rcnt = s_q.rcnt - 20'h1;
         end
      end
      // ---------------------------------------------
      // apb slave, one wait state
      // ---------------------------------------------
      s_d.pready  = PSEL_I && PENABLE_I && !s_q.pready;
      s_d.pslverr = 1'b0;
      if (!s_q.pready && PSEL_I && PENABLE_I) begin
         unique case (PADDR_I)
            todc_pkg::A_CMD:   s_d.prdata = {24'h0, (s_q.cs == todc_pkg::CS_ACK) ? todc_pkg::ST_ACK
                                                                                : todc_pkg::ST_READY};
            todc_pkg::A_SEC:   s_d.prdata = {24'h0, s_q.t.sec};
            todc_pkg::A_MIN:   s_d.prdata = {24'h0, s_q.t.min};
            todc_pkg::A_HR:    s_d.prdata = {24'h0, s_q.t.hr};
            todc_pkg::A_DOW:   s_d.prdata = {29'h0, s_q.t.dow};
            todc_pkg::A_DATE:  s_d.prdata = {24'h0, s_q.t.date};
            todc_pkg::A_MON:   s_d.prdata = {24'h0, s_q.t.mon};
            todc_pkg::A_YR:    s_d.prdata = {24'h0, s_q.t.yr};
            todc_pkg::A_HR12:  s_d.prdata = {24'h0, h12_w};
            todc_pkg::A_BIN:   s_d.prdata = {15'h0, bin_w};
            todc_pkg::A_ASEC:  s_d.prdata = {24'h0, s_q.al.sec};
            todc_pkg::A_AMIN:  s_d.prdata = {24'h0, s_q.al.min};
            todc_pkg::A_AHR:   s_d.prdata = {24'h0, s_q.al.hr};
            todc_pkg::A_ADATE: s_d.prdata = {24'h0, s_q.al.date};
            todc_pkg::A_AMON:  s_d.prdata = {24'h0, s_q.al.mon};
            todc_pkg::A_ACTL:  s_d.prdata = {29'h0, s_q.actl};
            todc_pkg::A_RLD:   s_d.prdata = {12'h0, s_q.rld};
            todc_pkg::A_RCNT:  s_d.prdata = {12'h0, s_q.rcnt};
            todc_pkg::A_ISTAT: s_d.prdata = {29'h0, s_q.ist};
            todc_pkg::A_IMASK: s_d.prdata = {29'h0, s_q.imsk};
            todc_pkg::A_USER:  s_d.prdata = {8'h0, s_q.user};
            todc_pkg::A_TENTH: s_d.prdata = {28'h0, s_q.t.tenth};
            default: begin
               s_d.prdata  = 32'h0;
               s_d.pslverr = 1'b1;
            end
         endcase
      end
      if (rd_w && PADDR_I == todc_pkg::A_CMD) begin
         s_d.cs = todc_pkg::CS_READY;
      end
      if (wr_w) begin
         unique case (PADDR_I)
            todc_pkg::A_CMD: begin
               // commands while the ack is unread are refused
               if (s_q.cs == todc_pkg::CS_READY && wd_w != todc_pkg::ST_ACK) begin
                  s_d.cs = todc_pkg::CS_ACK;
                  unique case (wd_w)
                     todc_pkg::CM_OFF:   s_d.dm = todc_pkg::DM_OFF;
                     todc_pkg::CM_D12:   s_d.dm = todc_pkg::DM_12;
                     todc_pkg::CM_D24:   s_d.dm = todc_pkg::DM_24;
                     todc_pkg::CM_DDATE: s_d.dm = todc_pkg::DM_DATE;
                     todc_pkg::CM_DUSER: s_d.dm = todc_pkg::DM_USER;
                     todc_pkg::CM_XTAL:  s_d.tb = todc_pkg::TB_XTAL;
                     todc_pkg::CM_L50:   s_d.tb = todc_pkg::TB_L50;
                     todc_pkg::CM_L60:   s_d.tb = todc_pkg::TB_L60;
                     todc_pkg::CM_IDIS:  s_d.imsk = 3'h0;
                     default:            s_d.cs = todc_pkg::CS_READY;
                  endcase
               end
            end
            todc_pkg::A_SEC: begin
               s_d.t.sec   = wd_w;
               s_d.t.tenth = 4'h0;
               s_d.div     = 22'h0;
            end
            todc_pkg::A_MIN:   s_d.t.min = wd_w;
            todc_pkg::A_HR:    s_d.t.hr = wd_w;
            todc_pkg::A_DOW:   s_d.t.dow = wd_w[2:0];
            todc_pkg::A_DATE:  s_d.t.date = wd_w;
            todc_pkg::A_MON:   s_d.t.mon = wd_w;
            todc_pkg::A_YR:    s_d.t.yr = wd_w;
            todc_pkg::A_ASEC:  s_d.al.sec = wd_w;
            todc_pkg::A_AMIN:  s_d.al.min = wd_w;
            todc_pkg::A_AHR:   s_d.al.hr = wd_w;
            todc_pkg::A_ADATE: s_d.al.date = wd_w;
            todc_pkg::A_AMON:  s_d.al.mon = wd_w;
            todc_pkg::A_ACTL:  s_d.actl = wd_w[2:0];
            todc_pkg::A_RLD: begin
               s_d.rld  = (PWDATA_I[19:0] == 20'h0) ? 20'h1
                        : (PWDATA_I[19:0] > todc_pkg::DAY_TICKS) ? todc_pkg::DAY_TICKS : PWDATA_I[19:0];
               s_d.rcnt = s_d.rld;
            end
            todc_pkg::A_IMASK: s_d.imsk = wd_w[2:0];
            todc_pkg::A_USER:  s_d.user = PWDATA_I[23:0];
            default: ;
         endcase
      end
      // ---------------------------------------------
      // interrupts: set wins over write-one clear
      // ---------------------------------------------
      s_d.ist = s_q.ist & ~((wr_w && PADDR_I == todc_pkg::A_ISTAT) ? wd_w[2:0] : 3'h0);
      s_d.ist[todc_pkg::I_ABS] = s_d.ist[todc_pkg::I_ABS] | abs_w;
      s_d.ist[todc_pkg::I_REL] = s_d.ist[todc_pkg::I_REL] | rel_w;
      s_d.ist[todc_pkg::I_PF]  = s_d.ist[todc_pkg::I_PF] | s_q.pf2;
      s_d.irq = |(s_q.ist & s_q.imsk);
      // ---------------------------------------------
      // display scan
      // ---------------------------------------------
      if (s_q.scan >= 16'(SCAN_CYCLES - 1)) begin
         s_d.scan = 16'h0;
         s_d.dig  = (s_q.dig >= todc_pkg::LAST_DIGIT) ? 3'h0 : s_q.dig + 3'h1;
      end else begin
         s_d.scan = s_q.scan + 16'h1;
      end
      unique case (s_q.dm)
         todc_pkg::DM_12:   disp_w = {h12_w & 8'h7f, s_q.t.min, s_q.t.sec};
         todc_pkg::DM_24:   disp_w = {s_q.t.hr, s_q.t.min, s_q.t.sec};
         todc_pkg::DM_DATE: disp_w = {s_q.t.mon, s_q.t.date, s_q.t.yr};
         todc_pkg::DM_USER: disp_w = s_q.user;
         default:           disp_w = {6{todc_pkg::BLANK}};
      endcase
      s_d.bcd  = disp_w[{s_d.dig, 2'h0} +: 4]; // nibble moves with its digit select
      s_d.tind = (s_q.dm == todc_pkg::DM_12) || (s_q.dm == todc_pkg::DM_24);
      s_d.dind = (s_q.dm == todc_pkg::DM_DATE);
      s_d.pm   = s_d.tind && h12_w[7];
      s_d.am   = s_d.tind && !h12_w[7];
   end

   // ---------------------------------------------
   // 12-hour and binary views of the bcd time
   // ---------------------------------------------
   logic [6:0] hb_w, hm_w;
   always_comb begin
      hb_w  = todc_pkg::bcd2bin(s_q.t.hr);
      hm_w  = (hb_w == 7'h0) ? 7'd12 : (hb_w > 7'd12) ? 7'(hb_w - 7'd12) : hb_w;
      h12_w = {hb_w >= 7'd12, (hm_w >= 7'd10) ? {3'h1, 4'(hm_w - 7'd10)} : {3'h0, hm_w[3:0]}};
      bin_w = 17'(17'(hb_w) * 17'd3600 + 17'(todc_pkg::bcd2bin(s_q.t.min)) * 17'd60
                  + 17'(todc_pkg::bcd2bin(s_q.t.sec)));
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         s_q        <= '0;
         s_q.tb     <= todc_pkg::TB_XTAL;
         s_q.t.dow  <= 3'h1;
         s_q.t.date <= todc_pkg::R_ONE;
         s_q.t.mon  <= todc_pkg::R_ONE;
         s_q.al.date <= todc_pkg::R_ONE;
         s_q.al.mon <= todc_pkg::R_ONE;
         s_q.rld    <= 20'h1;
         s_q.rcnt   <= 20'h1;
         s_q.ist    <= 3'h4;
         s_q.dm     <= todc_pkg::DM_OFF;
         s_q.cs     <= todc_pkg::CS_READY;
         s_q.bcd    <= todc_pkg::BLANK;
      end else begin
         s_q <= s_d;
      end
   end

   assign PRDATA_O       = s_q.prdata;
   assign PREADY_O       = s_q.pready;
   assign PSLVERR_O      = s_q.pslverr;
   assign IRQ_OUT_O      = s_q.irq;
   assign DIGIT_SELECT_O = s_q.dig;
   assign BCD_O          = s_q.bcd;
   assign TIME_IND_O     = s_q.tind;
   assign DATE_IND_O     = s_q.dind;
   assign AM_O           = s_q.am;
   assign PM_O           = s_q.pm;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESETN_I);
   property p_secwrap;
      tick_w && !wr_w && s_q.t.tenth == 4'h9 && s_q.t.sec == 8'h59 |=> s_q.t.sec == 8'h00;
   endproperty
   a_secwrap: assert property (p_secwrap) else $error("seconds did not wrap");
   property p_h12;
      s_q.t.hr == 8'h13 |-> h12_w == 8'h81;
   endproperty
   a_h12: assert property (p_h12) else $error("bad 12-hour value");
   property p_bin;
      s_q.t.hr == 8'h23 && s_q.t.min == 8'h59 && s_q.t.sec == 8'h59 |-> bin_w == 17'd86399;
   endproperty
   a_bin: assert property (p_bin) else $error("bad binary time");
   property p_leap;
      tick_w && !wr_w && s_q.t.tenth == 4'h9 && s_q.t.sec == 8'h59 && s_q.t.min == 8'h59
      && s_q.t.hr == 8'h23 && s_q.t.mon == 8'h02 && s_q.t.date == 8'h28 && s_q.t.yr == 8'h04
      |=> s_q.t.date == 8'h29;
   endproperty
   a_leap: assert property (p_leap) else $error("leap day skipped");
   property p_abs;
      abs_w |=> s_q.ist[todc_pkg::I_ABS] ##1 (s_q.irq || !s_q.imsk[todc_pkg::I_ABS]);
   endproperty
   a_abs: assert property (p_abs) else $error("absolute event lost");
   property p_rel;
      rel_w && !wr_w |=> s_q.rcnt == $past(s_q.rld) && s_q.ist[todc_pkg::I_REL];
   endproperty
   a_rel: assert property (p_rel) else $error("down counter did not reload");
   property p_read;
      rd_w && !tick_w |=> $stable(s_q.t);
   endproperty
   a_read: assert property (p_read) else $error("read disturbed time");
   property p_xtal;
      $rose(RESETN_I) |-> s_q.tb == todc_pkg::TB_XTAL && s_q.ist[todc_pkg::I_PF];
   endproperty
   a_xtal: assert property (p_xtal) else $error("bad state after reset");
   property p_cmd;
      wr_w && PADDR_I == todc_pkg::A_CMD && wd_w == todc_pkg::CM_L60 && s_q.cs == todc_pkg::CS_READY
      |=> s_q.cs == todc_pkg::CS_ACK && s_q.tb == todc_pkg::TB_L60;
   endproperty
   a_cmd: assert property (p_cmd) else $error("command not taken");
   property p_irq;
      (s_q.ist & s_q.imsk) != 3'h0 |=> s_q.irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");
   c_abs:  cover property (abs_w);
   c_rel:  cover property (rel_w);
   c_irq:  cover property ($rose(s_q.irq));
   c_date: cover property (s_q.dind && s_q.dig == 3'h5);
endmodule : todc_top

//--- bench/todc_host_model.sv
// apb host model for the clock's register bus
`timescale 1ns/1ps
module todc_host_model (
   // clock
   input  wire logic        clk_i,
   // apb master side
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i
);
   initial begin
      {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
   end
   // request held until pready is seen high at an edge, or for at most 20 edges of the access phase
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e, output logic to);
      int n;
      @(posedge clk_i);
      psel_o   <= 1'h1;
      pwrite_o <= w;
      paddr_o  <= a;
      pwdata_o <= d;
      @(posedge clk_i);
      penable_o <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_i !== 1'h1 && n < 20);
      r  = prdata_i;
      e  = pslverr_i;
      to = (pready_i !== 1'h1);
      psel_o    <= 1'h0;
      penable_o <= 1'h0;
   endtask : xfer
endmodule : todc_host_model

//--- bench/todc_top_test.sv
// self-checking bench of the time of day calendar clock
`timescale 1ns/1ps
module todc_top_test;
   localparam int TK = 20;
   logic        clk = 1'h0, rstn = 1'h0, line = 1'h0, pf = 1'h0;
   logic        psel, pen, pwr, rdy, err, e, to, tind, dind, am, pm, irq;
   logic [7:0]  pa;
   logic [31:0] pwd, prd, rd;
   logic [2:0]  dsel;
   logic [3:0]  bcd;
   int          error_cnt = 0, comparisons = 0, seed = 22, r, n, u;
   // register model, one word per register index
   int          mdl [0:63];
   always #12.5 clk = ~clk;
   todc_top #(.TICK_CYCLES(TK), .SCAN_CYCLES(4)) u_dut (.CLK_SYS_I(clk), .RESETN_I(rstn), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
      .PSLVERR_O(err), .LINE_TB_I(line), .POWER_FAIL_I(pf), .IRQ_OUT_O(irq), .DIGIT_SELECT_O(dsel),
      .BCD_O(bcd), .TIME_IND_O(tind), .DATE_IND_O(dind), .AM_O(am), .PM_O(pm));
   todc_host_model u_host (.clk_i(clk), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(pa),
      .pwdata_o(pwd), .prdata_i(prd), .pready_i(rdy), .pslverr_i(err));
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task end_of_test;
      $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(w, a, d, rd, e, to);
      chk("bus timeout", 32'h0, {31'h0, to});
      if (to) begin
         end_of_test();
      end
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      mdl[a >> 2] = d;
      bus(1'h1, a, d);
   endtask : wr
   task rc(input logic [7:0] a, input logic [31:0] x);
      bus(1'h0, a, 32'h0);
      chk($sformatf("reg %h", a), x, rd);
   endtask : rc
   // irq wait bounded, since the interval is known
   task wait_irq(input int lim);
      repeat (2) @(posedge clk);
      n = 0;
      while (irq !== 1'h1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      chk("irq", 32'h1, {31'h0, irq});
   endtask : wait_irq
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
      rc(todc_pkg::A_CMD, 32'hee);
      rc(todc_pkg::A_DOW, 32'h1);
      rc(todc_pkg::A_ISTAT, 32'h4);
      bus(1'h0, 8'hfc, 32'h0);
      chk("slverr", 32'h1, {31'h0, e});
      wr(todc_pkg::A_ISTAT, 32'h4);
      wr(todc_pkg::A_SEC, 32'h0);
      repeat (10 * TK) @(posedge clk);
      rc(todc_pkg::A_SEC, 32'h1);
      @(posedge clk) pf <= 1'h1;
      repeat (4) @(posedge clk);
      pf <= 1'h0;
      rc(todc_pkg::A_ISTAT, 32'h4);
      wr(todc_pkg::A_IMASK, 32'h3);
      wr(todc_pkg::A_CMD, 32'h55);
      rc(todc_pkg::A_CMD, 32'hee);
      for (int c = 8'he0; c <= 8'he8; c++) begin
         wr(todc_pkg::A_CMD, c);
         rc(todc_pkg::A_CMD, 32'hff);
         rc(todc_pkg::A_CMD, 32'hee);
         chk("date ind", {31'h0, c == todc_pkg::CM_DDATE}, {31'h0, dind});
      end
      rc(todc_pkg::A_IMASK, 32'h0);
      // line timebase: stale divider and free crystal would both give 2
      for (int m = 5; m <= 6; m++) begin
         wr(todc_pkg::A_CMD, (m == 5) ? todc_pkg::CM_L50 : todc_pkg::CM_L60);
         rc(todc_pkg::A_CMD, 32'hff);
         wr(todc_pkg::A_SEC, 32'h0);
         repeat (10 * m + 2) begin
            @(posedge clk) line <= 1'h1;
            repeat (4) @(posedge clk);
            line <= 1'h0;
            repeat (4) @(posedge clk);
         end
         rc(todc_pkg::A_SEC, 32'h1);
      end
      wr(todc_pkg::A_CMD, todc_pkg::CM_XTAL);
      rc(todc_pkg::A_CMD, 32'hff);
      for (int y = 4; y <= 5; y++) begin
         wr(todc_pkg::A_YR, y);
         wr(todc_pkg::A_MON, 32'h2);
         wr(todc_pkg::A_DATE, 32'h28);
         wr(todc_pkg::A_DOW, 32'h7);
         wr(todc_pkg::A_HR, 32'h23);
         wr(todc_pkg::A_MIN, 32'h59);
         wr(todc_pkg::A_ADATE, (y % 4 == 0) ? 32'h29 : 32'h1);
         wr(todc_pkg::A_AMON, (y % 4 == 0) ? 32'h2 : 32'h3);
         wr(todc_pkg::A_ACTL, 32'h3);
         wr(todc_pkg::A_ISTAT, 32'h7);
         wr(todc_pkg::A_SEC, 32'h59);
         rc(todc_pkg::A_HR12, 32'h91);
         rc(todc_pkg::A_BIN, 32'd86399);
         repeat (10 * TK) @(posedge clk);
         rc(todc_pkg::A_DATE, (y % 4 == 0) ? 32'h29 : 32'h1);
         rc(todc_pkg::A_MON, (y % 4 == 0) ? 32'h2 : 32'h3);
         rc(todc_pkg::A_HR, 32'h0);
         rc(todc_pkg::A_DOW, 32'h1);
         rc(todc_pkg::A_ISTAT, 32'h1);
      end
      r = 1 + ($random(seed) & 3);
      wr(todc_pkg::A_ACTL, 32'h0);
      wr(todc_pkg::A_ISTAT, 32'h7);
      wr(todc_pkg::A_IMASK, 32'h2);
      wr(todc_pkg::A_RLD, r);
      wr(todc_pkg::A_ACTL, 32'h4);
      bus(1'h0, todc_pkg::A_RCNT, 32'h0);
      chk("count range", 32'h1, {31'h0, rd >= 1 && rd <= r});
      for (int k = 0; k < 2; k++) begin
         wr(todc_pkg::A_ISTAT, 32'h2);
         wait_irq(r * TK + 20);
         rc(todc_pkg::A_ISTAT, 32'h2);
      end
      wr(todc_pkg::A_IMASK, 32'h0);
      repeat (2) @(posedge clk);
      chk("masked irq", 32'h0, {31'h0, irq});
      // user digits on the scan, then 12-hour view and its indicators
      u = $random(seed);
      wr(todc_pkg::A_USER, u);
      rc(todc_pkg::A_USER, mdl[todc_pkg::A_USER >> 2] & 32'hffffff);
      wr(todc_pkg::A_CMD, todc_pkg::CM_DUSER);
      rc(todc_pkg::A_CMD, 32'hff);
      repeat (30) begin
         @(posedge clk);
         chk("user digit", (u >> {dsel, 2'h0}) & 32'hf, {28'h0, bcd});
      end
      chk("time ind", 32'h0, {31'h0, tind});
      wr(todc_pkg::A_HR, 32'h13);
      wr(todc_pkg::A_CMD, todc_pkg::CM_D12);
      rc(todc_pkg::A_CMD, 32'hff);
      repeat (30) begin
         @(posedge clk);
         if (dsel == 3'h4) chk("hour digit", 32'h1, {28'h0, bcd});
      end
      chk("indicators", 32'h9, {28'h0, tind, dind, am, pm});
      end_of_test();
   end
endmodule : todc_top_test
